// ===== rtl/scb_consts.svh
// Purpose: Shared constants of the SDRAM command and burst controller.
// Assumes: 50 MHz system clock, AXI4-Lite register port.
// Notes:   Timing figures are plain defaults for the attached memory grade.
`ifndef SCB_CONSTS_SVH
`define SCB_CONSTS_SVH
`define SCB_CLK_NS     20
`define SCB_T_RCD_NS   20
`define SCB_T_RP_NS    20
`define SCB_T_WR_NS    15
`define SCB_T_XSR_NS   80
`define SCB_T_REF_MS   64
`define SCB_CYC(ns)    (((ns) + `SCB_CLK_NS - 1) / `SCB_CLK_NS)
`define SCB_REG_CTRL   5'h00
`define SCB_REG_ADDR   5'h04
`define SCB_REG_CFG    5'h08
`define SCB_REG_STAT   5'h0C
`define SCB_REG_WDATA  5'h10
`define SCB_REG_RDATA  5'h14
`define SCB_RESP_OK    2'h0
`define SCB_RESP_ERR   2'h2
`define SCB_CMD_NOP    4'h7
`define SCB_CMD_ACT    4'h3
`define SCB_CMD_RD     4'h5
`define SCB_CMD_WR     4'h4
`define SCB_CMD_BST    4'h6
`define SCB_CMD_PRE    4'h2
`define SCB_CMD_SREF   4'h1
`define SCB_CMD_DESEL  4'hF
`define SCB_OP_HI      2
`define SCB_OP_LO      0
`define SCB_AP_POS     3
`define SCB_BANK_HI    5
`define SCB_BANK_LO    4
`define SCB_BL_HI      2
`define SCB_BL_LO      0
`define SCB_CL3_POS    3
`define SCB_BL_FULL    3'h7
`define SCB_FULL_BEATS 4'h8
`define SCB_AP_BIT     10
`define SCB_RD_PIPE    3
`endif

// ===== rtl/scb_pkg.sv
// Purpose: Types of the SDRAM command and burst controller.
// Assumes: Nothing beyond the constants header.
// Notes:   The command field packs chip select, row, column and write strobes.
`default_nettype none
package scb_pkg;
  typedef logic [21:0] scb_cnt_t;
  typedef enum logic [2:0] {
    OP_NOP, OP_ACT, OP_READ, OP_WRITE, OP_PRE, OP_SREF, OP_PDOWN, OP_SUSP
  } scb_op_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT, ST_WPRE, ST_WRITE, ST_READ, ST_LOWP, ST_EXIT
  } scb_state_t;
  typedef struct packed {
    logic        cke;
    logic [3:0]  cmd;
    logic        dqm;
    logic        bank_select_msb;
    logic        bank_select_lsb;
    logic [12:0] addr;
  } scb_pins_t;
endpackage : scb_pkg
`default_nettype wire

// ===== rtl/scb_mem.sv
// Purpose: Eight-word burst buffer with a registered read port.
// Assumes: One write and one read per clock.
// Notes:   Read data lag the read address by one clock.
`default_nettype none
module scb_mem (
  // Clock
  input  wire logic        aclk,
  // Write port
  input  wire logic        we,
  input  wire logic [2:0]  waddr,
  input  wire logic [15:0] wdata,
  // Read port
  input  wire logic [2:0]  raddr,
  output logic      [15:0] rdata_q
);
  logic [15:0] mem_q [8];

  always_ff @(posedge aclk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
    rdata_q <= mem_q[raddr];
  end
endmodule : scb_mem
`default_nettype wire

// ===== rtl/scb_ctrl.sv
// Purpose: Host controller that drives an SDRAM through its command pins.
// Assumes: Software orders one command at a time over AXI4-Lite.
// Notes:   Bursts move through an eight-word buffer; full page stops at 8.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`include "scb_consts.svh"
`default_nettype none

// Summary of operation
// - CS and CAS low, RAS WE high: read
// - CS CAS WE low, RAS high: write
// - Write data from command cycle, every edge
// - Mask read data on first two write cycles
// - Release data bus before read data arrive
// - Burst stop ends burst, row stays open
// - No read, write, precharge during auto-precharge
// - No auto-precharge with full page bursts
// - Write auto-precharge: wait recovery plus precharge
// - Precharge decode; wait precharge period before activate
// - Self refresh entry, hold, exit wait
// - Leave power down in time; NOP next
// - Wait row-to-column delay after activate
module scb_ctrl import scb_pkg::*; #(
  parameter int unsigned REF_CYC = `SCB_T_REF_MS * 1000000 / `SCB_CLK_NS
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Memory pins
  output var scb_pins_t    sd_pins,
  output logic      [15:0] sd_dq_o,
  output logic             sd_dq_oe_n,
  input  wire logic [15:0] sd_dq_i
);
  localparam scb_cnt_t C_RCD = scb_cnt_t'(`SCB_CYC(`SCB_T_RCD_NS));
  localparam scb_cnt_t C_RP  = scb_cnt_t'(`SCB_CYC(`SCB_T_RP_NS));
  localparam scb_cnt_t C_DAL = scb_cnt_t'(`SCB_CYC(`SCB_T_WR_NS) + `SCB_CYC(`SCB_T_RP_NS));
  localparam scb_cnt_t C_XSR = scb_cnt_t'(`SCB_CYC(`SCB_T_XSR_NS));
  localparam scb_cnt_t C_REF = scb_cnt_t'(REF_CYC - 1);
  localparam scb_cnt_t C_PIPE = scb_cnt_t'(`SCB_RD_PIPE);

  scb_state_t  st_q, st_d;
  scb_cnt_t    cnt_q, cnt_d;
  scb_pins_t   pins_d;
  logic [15:0] dq_d;
  logic        oe_n_d;
  logic [15:0] dq_s1_q, dq_s2_q;
  logic [12:0] addr_q;
  logic [3:0]  cfg_q;
  logic        ap_q, sref_q;
  logic [1:0]  bank_q;
  logic [2:0]  wptr_q, rptr_q;
  logic [3:0]  cap_q;
  logic        rpend_q;
  logic [4:0]  rsel_q;
  logic        rbad_q;
  logic [15:0] mem_rdata;

  //////////////////////////////////////////////////////////////////////////////
  // Register decode.
  wire  [4:0]  waddr    = s_axi_awaddr[4:0];
  wire         wbad     = (s_axi_awaddr[31:5] != 27'h0) || (waddr > `SCB_REG_RDATA)
                          || (waddr[1:0] != 2'h0);
  wire         wr_hit   = s_axi_awready && !wbad;
  wire         w_ctrl   = wr_hit && (waddr == `SCB_REG_CTRL);
  wire         w_addr   = wr_hit && (waddr == `SCB_REG_ADDR);
  wire         w_cfg    = wr_hit && (waddr == `SCB_REG_CFG) && (st_q == ST_IDLE);
  wire         w_wdata  = wr_hit && (waddr == `SCB_REG_WDATA);
  wire  [15:0] wmask    = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire  [15:0] addr_new = ({3'h0, addr_q} & ~wmask) | (s_axi_wdata[15:0] & wmask);
  wire         go       = w_ctrl && s_axi_wstrb[0] && ((st_q == ST_IDLE) || (st_q == ST_LOWP));
  wire scb_op_t op_w    = scb_op_t'(s_axi_wdata[`SCB_OP_HI:`SCB_OP_LO]);
  wire  [4:0]  raddr    = s_axi_araddr[4:0];
  wire         rbad     = (s_axi_araddr[31:5] != 27'h0) || (raddr > `SCB_REG_RDATA)
                          || (raddr[1:0] != 2'h0);
  wire         r_pop    = s_axi_arready && !rbad && (raddr == `SCB_REG_RDATA);

  //////////////////////////////////////////////////////////////////////////////
  // Burst geometry.
  wire         full     = (cfg_q[`SCB_BL_HI:`SCB_BL_LO] == `SCB_BL_FULL);
  wire  [3:0]  beats    = full ? `SCB_FULL_BEATS :
                          (cfg_q[2] ? 4'h1 : (4'h1 << cfg_q[1:0]));
  wire scb_cnt_t cl     = cfg_q[`SCB_CL3_POS] ? scb_cnt_t'(3) : scb_cnt_t'(2);
  wire scb_cnt_t rd_first = cl + C_PIPE;
  wire scb_cnt_t rd_last  = rd_first + scb_cnt_t'(beats) - scb_cnt_t'(1);
  wire scb_cnt_t wr_last  = full ? scb_cnt_t'(`SCB_FULL_BEATS) : scb_cnt_t'(beats - 4'h1);
  wire         ap_eff   = ap_q && !full;
  wire  [12:0] col_addr = {addr_q[12:11], ap_eff, addr_q[9:0]};
  wire         stop_now = full && (cnt_q == scb_cnt_t'(`SCB_FULL_BEATS));
  wire         cap_hit  = (st_q == ST_READ) && (cnt_q >= rd_first) && (cap_q < beats);

  //////////////////////////////////////////////////////////////////////////////
  // Burst buffer: captures read beats, else takes words written by software.
  wire         mem_we    = cap_hit || w_wdata;
  wire  [2:0]  mem_waddr = cap_hit ? cap_q[2:0] : wptr_q;
  wire  [15:0] mem_wdata = cap_hit ? dq_s2_q : s_axi_wdata[15:0];
  wire  [2:0]  mem_raddr = (st_q == ST_WRITE) ? (cnt_q[2:0] + 3'h1) :
                           (st_q == ST_WPRE) ? 3'h0 : rptr_q;

  scb_mem u_mem (
    .aclk    (aclk),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .raddr   (mem_raddr),
    .rdata_q (mem_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Command sequencer.
  always_comb begin
    st_d       = st_q;
    cnt_d      = cnt_q + scb_cnt_t'(1);
    pins_d     = sd_pins;
    pins_d.cmd = `SCB_CMD_NOP;
    pins_d.cke = 1'b1;
    pins_d.dqm = 1'b0;
    dq_d       = sd_dq_o;
    oe_n_d     = 1'b1;
    unique case (st_q)
      ST_IDLE: begin
        cnt_d = '0;
        if (go) begin
          pins_d.bank_select_msb = s_axi_wdata[`SCB_BANK_HI];
          pins_d.bank_select_lsb = s_axi_wdata[`SCB_BANK_LO];
          pins_d.addr            = addr_q;
          unique case (op_w)
            OP_NOP: begin
            end
            OP_ACT: begin
              pins_d.cmd = `SCB_CMD_ACT;
              st_d       = ST_WAIT;
              cnt_d      = C_RCD;
            end
            OP_READ: begin
              st_d = ST_READ;
            end
            OP_WRITE: begin
              st_d = ST_WPRE;
            end
            OP_PRE: begin
              pins_d.cmd                  = `SCB_CMD_PRE;
              pins_d.addr[`SCB_AP_BIT]    = s_axi_wdata[`SCB_AP_POS];
              st_d                        = ST_WAIT;
              cnt_d                       = C_RP;
            end
            OP_SREF: begin
              pins_d.cmd = `SCB_CMD_SREF;
              pins_d.cke = 1'b0;
              st_d       = ST_LOWP;
            end
            OP_PDOWN: begin
              pins_d.cmd = `SCB_CMD_DESEL;
              pins_d.cke = 1'b0;
              st_d       = ST_LOWP;
            end
            OP_SUSP: begin
              pins_d.cke = 1'b0;
              st_d       = ST_LOWP;
            end
          endcase
        end
      end
      ST_WAIT: begin
        cnt_d = cnt_q - scb_cnt_t'(1);
        if (cnt_q <= scb_cnt_t'(1)) begin
          st_d = ST_IDLE;
        end
      end
      ST_WPRE: begin
        // Masks any read data that would land on the first two write beats.
        pins_d.dqm = 1'b1;
        if (cnt_q == scb_cnt_t'(1)) begin
          st_d  = ST_WRITE;
          cnt_d = '0;
        end
      end
      ST_WRITE: begin
        pins_d.addr = col_addr;
        if (cnt_q == '0) begin
          pins_d.cmd = `SCB_CMD_WR;
        end else if (stop_now) begin
          pins_d.cmd = `SCB_CMD_BST;
        end
        dq_d   = mem_rdata;
        oe_n_d = stop_now;
        if (cnt_q == wr_last) begin
          st_d  = ap_eff ? ST_WAIT : ST_IDLE;
          cnt_d = C_DAL;
        end
      end
      ST_READ: begin
        pins_d.addr = col_addr;
        if (cnt_q == '0) begin
          pins_d.cmd = `SCB_CMD_RD;
        end else if (stop_now) begin
          pins_d.cmd = `SCB_CMD_BST;
        end
        if (cnt_q == rd_last) begin
          // An auto-precharged bank is left alone until it has closed.
          st_d  = ap_eff ? ST_WAIT : ST_IDLE;
          cnt_d = C_RP;
        end
      end
      ST_LOWP: begin
        pins_d.cmd = `SCB_CMD_DESEL;
        pins_d.cke = 1'b0;
        // Power down and suspend do not refresh, so they are cut short in time.
        if (go || (!sref_q && (cnt_q >= C_REF))) begin
          pins_d.cmd = `SCB_CMD_NOP;
          pins_d.cke = 1'b1;
          st_d       = ST_EXIT;
          cnt_d      = sref_q ? C_XSR : scb_cnt_t'(1);
        end
      end
      ST_EXIT: begin
        cnt_d = cnt_q - scb_cnt_t'(1);
        if (cnt_q <= scb_cnt_t'(1)) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q       <= ST_IDLE;
      cnt_q      <= '0;
      sd_pins    <= '{cke: 1'b1, cmd: `SCB_CMD_DESEL, default: '0};
      sd_dq_o    <= '0;
      sd_dq_oe_n <= 1'b1;
    end else begin
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      sd_pins    <= pins_d;
      sd_dq_o    <= dq_d;
      sd_dq_oe_n <= oe_n_d;
    end
  end

  // Data pins are asynchronous to the controller, so two stages precede capture.
  always_ff @(posedge aclk) begin
    dq_s1_q <= sd_dq_i;
    dq_s2_q <= dq_s1_q;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Software registers and buffer pointers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_q <= '0;
      cfg_q  <= '0;
      ap_q   <= 1'b0;
      bank_q <= '0;
      sref_q <= 1'b0;
      wptr_q <= '0;
      rptr_q <= '0;
      cap_q  <= '0;
    end else begin
      if (w_addr) begin
        addr_q <= addr_new[12:0];
      end
      if (w_cfg && s_axi_wstrb[0]) begin
        cfg_q <= s_axi_wdata[3:0];
      end
      if (go && (st_q == ST_IDLE)) begin
        ap_q   <= s_axi_wdata[`SCB_AP_POS];
        bank_q <= s_axi_wdata[`SCB_BANK_HI:`SCB_BANK_LO];
        sref_q <= (op_w == OP_SREF);
      end
      if ((st_q == ST_WRITE) && (cnt_q == wr_last)) begin
        wptr_q <= '0;
      end else if (w_wdata) begin
        wptr_q <= wptr_q + 3'h1;
      end
      if ((st_q == ST_READ) && (cnt_q == '0)) begin
        rptr_q <= '0;
        cap_q  <= '0;
      end else begin
        rptr_q <= rptr_q + {2'h0, r_pop};
        cap_q  <= cap_q + {3'h0, cap_hit};
      end
    end
  end

  wire [31:0] rd_mux =
    (rsel_q == `SCB_REG_CTRL)  ? {26'h0, bank_q, ap_q, 3'h0} :
    (rsel_q == `SCB_REG_ADDR)  ? {19'h0, addr_q} :
    (rsel_q == `SCB_REG_CFG)   ? {28'h0, cfg_q} :
    (rsel_q == `SCB_REG_STAT)  ? {22'h0, wptr_q, cap_q, 1'b0,
                                  (st_q == ST_LOWP), (st_q != ST_IDLE)} :
    (rsel_q == `SCB_REG_RDATA) ? {16'h0, mem_rdata} : 32'h0;

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data are taken together, one write and one read at a time.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SCB_RESP_OK;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `SCB_RESP_OK;
      rpend_q       <= 1'b0;
      rsel_q        <= '0;
      rbad_q        <= 1'b0;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      if (s_axi_awready) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wbad ? `SCB_RESP_ERR : `SCB_RESP_OK;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !rpend_q && !s_axi_rvalid;
      rpend_q       <= s_axi_arready;
      if (s_axi_arready) begin
        rsel_q <= raddr;
        rbad_q <= rbad;
      end
      if (rpend_q) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= rbad_q ? `SCB_RESP_ERR : `SCB_RESP_OK;
        s_axi_rdata  <= rbad_q ? 32'h0 : rd_mux;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks on the driven pins.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_mask_lead;
    sd_pins.dqm ##1 sd_pins.dqm ##1 (!sd_pins.dqm && sd_pins.cmd == `SCB_CMD_WR);
  endsequence
  sequence s_eight_beats;
    !sd_dq_oe_n [*8] ##1 sd_dq_oe_n;
  endsequence

  chk_read_decode: assert property (
    (go && st_q == ST_IDLE && op_w == OP_READ) |-> ##2 (sd_pins.cmd == `SCB_CMD_RD))
    else $error("read command not driven");
  chk_write_decode: assert property (
    (go && st_q == ST_IDLE && op_w == OP_WRITE) |-> ##4 (sd_pins.cmd == `SCB_CMD_WR))
    else $error("write command not driven");
  chk_write_beats: assert property (
    (sd_pins.cmd == `SCB_CMD_WR && !sd_dq_oe_n && beats == 4'h8) |-> s_eight_beats)
    else $error("write data beats wrong");
  chk_write_mask: assert property (
    (st_q == ST_WPRE && cnt_q == '0) |=> s_mask_lead)
    else $error("mask not raised ahead of write");
  chk_read_release: assert property (
    (sd_pins.cmd == `SCB_CMD_RD) |-> (sd_dq_oe_n && $past(sd_dq_oe_n)))
    else $error("bus driven at read");
  chk_page_stop: assert property (
    (sd_pins.cmd == `SCB_CMD_RD && full) |-> ##8 (sd_pins.cmd == `SCB_CMD_BST))
    else $error("full page read not stopped");
  chk_ap_alone: assert property (
    (sd_pins.cmd == `SCB_CMD_RD && sd_pins.addr[`SCB_AP_BIT])
      |=> (sd_pins.cmd == `SCB_CMD_NOP) [*4])
    else $error("command during auto-precharge");
  chk_no_ap_full: assert property (
    ((sd_pins.cmd == `SCB_CMD_RD || sd_pins.cmd == `SCB_CMD_WR) && full)
      |-> !sd_pins.addr[`SCB_AP_BIT])
    else $error("auto-precharge with full page");
  chk_pre_gap: assert property (
    (sd_pins.cmd == `SCB_CMD_PRE) |=> (sd_pins.cmd != `SCB_CMD_ACT))
    else $error("activate too soon after precharge");
  chk_sref_cke: assert property (
    (sd_pins.cmd == `SCB_CMD_SREF) |-> !sd_pins.cke)
    else $error("self refresh without clock enable low");
  chk_pd_exit_nop: assert property (
    $rose(sd_pins.cke) |-> (sd_pins.cmd == `SCB_CMD_NOP) ##1 (sd_pins.cmd == `SCB_CMD_NOP))
    else $error("no NOP after clock enable rise");
  chk_rcd_gap: assert property (
    (sd_pins.cmd == `SCB_CMD_ACT) |=> (sd_pins.cmd == `SCB_CMD_NOP))
    else $error("access too soon after activate");
endmodule : scb_ctrl
`default_nettype wire

// ===== test/scb_sdram_model.sv
// Purpose: Behavioural SDRAM that answers the controller on its pins.
// Assumes: Burst code, latency and order are handed in by the bench.
// Notes:   One column array serves every bank and row.
`default_nettype none
module scb_sdram_model import scb_pkg::*; (
  // Pins
  input  wire logic        aclk,
  input  wire scb_pins_t   pins,
  input  wire logic [15:0] dq_in,
  input  wire logic        dq_oe_n,
  // Mode
  input  wire logic [2:0]  bl_code,
  input  wire logic        cl3,
  input  wire logic        ilv,
  // Data and status
  output logic      [15:0] dq_out,
  output logic             viol_q
);
  logic [15:0] mem [0:511];
  logic [15:0] pd_q [0:2];
  logic [2:0]  pv_q;
  logic [15:0] last_q;
  logic        cke_q, rd_q, wr_q, ap_q, ex_q;
  logic [1:0]  bk_q;
  logic [8:0]  col_q, beat_q;
  logic [3:0]  open_q;
  wire logic [3:0] cmd = pins.cmd;
  wire logic [1:0] bank = {pins.bank_select_msb, pins.bank_select_lsb};
  wire logic       a10 = pins.addr[10];
  wire logic       full = (bl_code == 3'h7);
  wire logic [8:0] msk = full ? 9'h1FF : (bl_code > 3'h3) ? 9'h000 : (9'h001 << bl_code) - 9'h001;
  wire logic       nrd = cke_q && (cmd == 4'h5);
  wire logic       nwr = cke_q && (cmd == 4'h4);
  wire logic       arm = nrd || nwr;
  wire logic [8:0] st = arm ? pins.addr[8:0] : col_q;
  wire logic [8:0] bt = arm ? 9'h000 : beat_q;
  wire logic       ard = nrd || (rd_q && !nwr && cmd != 4'h6);
  wire logic       awr = nwr || (wr_q && !nrd && cmd != 4'h6);
  wire logic [8:0] ca = ilv ? st ^ (bt & msk) : (st & ~msk) | ((st + bt) & msk);
  wire logic       last = !full && (bt == msk);
  wire logic       apc = arm ? a10 && !full : ap_q;
  wire logic [1:0] bkc = arm ? bank : bk_q;
  wire logic [1:0] oi = cl3 ? 2'h2 : 2'h1;
  // A released bus shows the inverse of its last level.
  assign dq_out = pv_q[oi] ? pd_q[oi] : ~last_q;
  initial begin
    {cke_q, rd_q, wr_q, ap_q, ex_q, viol_q} = 6'h20;
    pv_q = 3'h0;
    open_q = 4'h0;
    last_q = 16'h5A5A;
  end
  always @(posedge aclk) begin
    cke_q <= pins.cke;
    last_q <= dq_out;
    ex_q <= !cke_q && pins.cke;
    if ((ex_q || (!cke_q && pins.cke)) && !cmd[3] && cmd != 4'h7) viol_q <= 1'b1;
    if (!dq_oe_n && pv_q[oi]) viol_q <= 1'b1;
    if (cke_q) begin
      pd_q[0] <= mem[ca];
      pd_q[1] <= pd_q[0];
      pd_q[2] <= pd_q[1];
      pv_q <= {pv_q[1:0], ard};
      if (awr && !pins.dqm) mem[ca] <= dq_in;
      if (awr && !pins.dqm && dq_oe_n) viol_q <= 1'b1;
      if (arm && (!open_q[bank] || (a10 && full))) viol_q <= 1'b1;
      if ((rd_q || wr_q) && ap_q && (arm || cmd == 4'h2)) viol_q <= 1'b1;
      if (cmd == 4'h1 && |open_q) viol_q <= 1'b1;
      rd_q <= ard && !last;
      wr_q <= awr && !last;
      col_q <= st;
      beat_q <= bt + 9'h001;
      ap_q <= apc;
      bk_q <= bkc;
      if (cmd == 4'h3) open_q[bank] <= 1'b1;
      if (cmd == 4'h2) open_q <= a10 ? 4'h0 : open_q & ~(4'h1 << bank);
      if ((ard || awr) && last && apc) open_q[bkc] <= 1'b0;
    end
  end
endmodule : scb_sdram_model
`default_nettype wire

// ===== test/test_sdram_command_burst_logic.sv
// Purpose: Self-checking bench of the SDRAM controller.
// Assumes: The memory model sits on the pins.
// Notes:   Low-power timeout cut to 50 cycles.
`include "scb_consts.svh"
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module test_sdram_command_burst_logic import scb_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int REF = 50;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, sd_dq_oe_n, viol, m_cl3, m_ilv;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  m_bl;
  logic [15:0] sd_dq_o, sd_dq_i, mdl_dq;
  scb_pins_t   sd_pins;
  int          failures, checks;
  assign sd_dq_i = sd_dq_oe_n ? mdl_dq : sd_dq_o;
  scb_ctrl #(.REF_CYC(REF)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sd_pins(sd_pins),
    .sd_dq_o(sd_dq_o), .sd_dq_oe_n(sd_dq_oe_n), .sd_dq_i(sd_dq_i));
  scb_sdram_model i_mdl (.aclk(aclk), .pins(sd_pins), .dq_in(sd_dq_o), .dq_oe_n(sd_dq_oe_n),
    .bl_code(m_bl), .cl3(m_cl3), .ilv(m_ilv), .dq_out(mdl_dq), .viol_q(viol));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask : axi_wr
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : axi_rd
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr({27'h0, a}, d, r);
    `CHK("write response", `SCB_RESP_OK, r)
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    logic [1:0] r;
    axi_rd({27'h0, a}, d, r);
    `CHK("read response", `SCB_RESP_OK, r)
  endtask : rd
  task automatic wait_idle;
    logic [31:0] d;
    int n;
    n = 0;
    do begin
      rd(`SCB_REG_STAT, d);
      n++;
    end while (d[0] !== 1'b0 && n < 200);
    `CHK("busy", 1'b0, d[0])
  endtask : wait_idle
  // Low-power orders return at once so the pins can be watched.
  task automatic op(input scb_op_t o, input logic ap, input logic [1:0] b, input logic [12:0] ad);
    wr(`SCB_REG_ADDR, {19'h0, ad});
    wr(`SCB_REG_CTRL, {26'h0, b, ap, o});
    if (o < OP_SREF) wait_idle;
  endtask : op
  task automatic set_cfg(input logic [2:0] code, input logic cl, input logic il);
    wr(`SCB_REG_CFG, {28'h0, cl, code});
    m_bl <= code;
    m_cl3 <= cl;
    m_ilv <= il;
  endtask : set_cfg
  function automatic logic [15:0] word_at(logic [8:0] s, int b, logic [2:0] code, logic il);
    logic [8:0] m;
    m = (code == 3'h7) ? 9'h1FF : 9'((1 << code) - 1);
    return 16'hA000 | 16'(il ? (s ^ 9'(b)) : ((s & ~m) | ((s + 9'(b)) & m)));
  endfunction : word_at
  task automatic rd_burst(input logic [8:0] s, input logic [2:0] code, input logic il,
                          input logic ap);
    logic [31:0] d;
    int n;
    n = (code == 3'h7) ? 8 : 1 << code;
    op(OP_READ, ap, 2'h0, {4'h0, s});
    rd(`SCB_REG_STAT, d);
    `CHK("beats captured", 4'(n), d[6:3])
    for (int b = 0; b < n; b++) begin
      rd(`SCB_REG_RDATA, d);
      `CHK("read word", word_at(s, b, code, il), d[15:0])
    end
  endtask : rd_burst
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd(`SCB_REG_STAT, d);
    `CHK("status after reset", 32'h0, d)
    axi_rd(32'h18, d, r);
    `CHK("unmapped read response", `SCB_RESP_ERR, r)
    `CHK("unmapped read data", 32'h0, d)
    axi_wr(32'h20, 32'h1, r);
    `CHK("unmapped write response", `SCB_RESP_ERR, r)
  endtask : t_regs
  task automatic t_write;
    set_cfg(3'h3, 1'b0, 1'b0);
    op(OP_ACT, 1'b0, 2'h0, 13'h0);
    for (int c = 0; c < 8; c++) wr(`SCB_REG_WDATA, 32'hA000 + c);
    op(OP_WRITE, 1'b0, 2'h0, 13'h0);
    for (int c = 0; c < 8; c++) `CHK("written word", 16'hA000 + c[15:0], i_mdl.mem[c])
  endtask : t_write
  task automatic t_modes;
    for (int k = 0; k < 8; k++) begin
      set_cfg({1'b0, k[2:1]}, k[1], k[0]);
      rd_burst(9'h003, {1'b0, k[2:1]}, k[0], 1'b0);
    end
  endtask : t_modes
  task automatic t_full;
    set_cfg(3'h7, 1'b1, 1'b0);
    for (int c = 6; c < 14; c++) wr(`SCB_REG_WDATA, 32'hA000 + c);
    op(OP_WRITE, 1'b0, 2'h0, 13'h006);
    rd_burst(9'h006, 3'h7, 1'b0, 1'b1);
    `CHK("row left open", 1'b1, i_mdl.open_q[0])
  endtask : t_full
  task automatic t_precharge;
    set_cfg(3'h2, 1'b1, 1'b0);
    rd_burst(9'h000, 3'h2, 1'b0, 1'b1);
    `CHK("auto-precharged bank", 1'b0, i_mdl.open_q[0])
    op(OP_ACT, 1'b0, 2'h1, 13'h0);
    op(OP_ACT, 1'b0, 2'h2, 13'h0);
    op(OP_PRE, 1'b0, 2'h2, 13'h0);
    `CHK("one bank closed", 4'h2, i_mdl.open_q)
    op(OP_ACT, 1'b0, 2'h3, 13'h0);
    op(OP_PRE, 1'b1, 2'h1, 13'h0);
    `CHK("all banks closed", 4'h0, i_mdl.open_q)
  endtask : t_precharge
  task automatic t_low;
    logic [31:0] d;
    int n;
    op(OP_SREF, 1'b0, 2'h0, 13'h0);
    repeat (4) @(posedge aclk);
    `CHK("cke in self refresh", 1'b0, sd_pins.cke)
    rd(`SCB_REG_STAT, d);
    `CHK("low power flag", 1'b1, d[1])
    op(OP_NOP, 1'b0, 2'h0, 13'h0);
    `CHK("cke after exit", 1'b1, sd_pins.cke)
    for (int k = 0; k < 2; k++) begin
      op(k ? OP_SUSP : OP_PDOWN, 1'b0, 2'h0, 13'h0);
      n = 0;
      while (sd_pins.cke !== 1'b1 && n < 4 * REF) begin
        @(posedge aclk);
        n++;
      end
      `CHK("forced exit", 1'b1, n >= REF - 8 && n <= REF + 8)
      wait_idle;
    end
  endtask : t_low
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (30000) @(posedge aclk);
    failures++;
    $display("unexpected timeout: expected finish seen hang");
    print_verdict;
  end
  initial begin
    failures = 0;
    checks = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h05;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hF;
    {m_bl, m_cl3, m_ilv} = 5'h00;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_write;
    t_modes;
    t_full;
    t_precharge;
    t_low;
    `CHK("model violations", 1'b0, viol)
    print_verdict;
  end
endmodule : test_sdram_command_burst_logic
`default_nettype wire
